// File: core/ilb_blinker.sv
// Interval timer channel, LED toggle and debounced speed switch
`timescale 1ns/100ps

// Behaviour
// - Timer runs in interval mode; first tick comes 2 ms after counting starts.
// - Count ticks; at 250 invert the LED pin.
// - Presses step LED half-period 500, 250, 125, 62.5 ms, then wrap.
// - Reload for press index 0..3 is 64000-1, 32000-1, 16000-1, 8000-1.
// - At tally 250 copy the pending reload into the reload register.
// - Switch event fires only on a falling edge, edge code 01h, enabled.
// - Each accepted switch event advances press count and updates pending reload.
// - Timer channel output disabled; channel only makes its tick.
// - Debounce wait is 6, 11, 21 or 41 ticks for indices 0..3.
// - After an edge wait the index's tick count (~10 ms if the reload in force matches the press index), act only if switch still pressed.
module ilb_blinker
  import ilb_pkg::*;
#(
  parameter logic [15:0] RELOAD_0 = ilb_pkg::RELOAD_0,
  parameter logic [15:0] RELOAD_1 = ilb_pkg::RELOAD_1,
  parameter logic [15:0] RELOAD_2 = ilb_pkg::RELOAD_2,
  parameter logic [15:0] RELOAD_3 = ilb_pkg::RELOAD_3
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Switch, active low when pressed
  input  wire logic              switch_input_pin_n,
  // LED and status
  output logic                   led_output_pin,
  output logic                   period_tick_event,
  output ilb_pkg::ilb_press_t    press_count
);
  import ilb_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic [7:0]     phase;
  logic [8:0]     phase_sum;
  logic           tclk_en;
  logic [15:0]    count;
  logic [15:0]    reload_value_register;
  logic [15:0]    pending_reload_value;
  logic           tick;
  logic [7:0]     tick_tally;
  logic           tally_wrap;
  logic           sw_prev;
  logic           switch_edge_event;
  ilb_sw_state_e  sw_state;
  logic [5:0]     deb_cnt;
  logic           deb_done;
  logic           still_pressed;

  // Reload value for a press index
  function automatic logic [15:0] reload_for(input ilb_press_t idx);
    unique case (idx)
      2'h0:    reload_for = RELOAD_0;
      2'h1:    reload_for = RELOAD_1;
      2'h2:    reload_for = RELOAD_2;
      default: reload_for = RELOAD_3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Timer clock enable
  // ----------------------------------------------------------------
  // Accumulator keeps the 32 MHz timer rate exact on average; 125/32 is not whole
  assign phase_sum = {1'h0, phase} + {1'h0, PHASE_STEP};
  assign tclk_en   = phase_sum >= {1'h0, PHASE_WRAP};

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      phase <= 8'h00;
    else if (tclk_en)
      phase <= 8'(phase_sum - {1'h0, PHASE_WRAP});
    else
      phase <= phase_sum[7:0];
  end

  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------
  // Channel output stays disabled: the tick is internal only
  assign tick       = tclk_en && (count == 16'h0000) && !TMR_OUT_ENABLE;
  assign tally_wrap = tick && (tick_tally == TALLY_LAST);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= RELOAD_0;
    else if (tick)
      count <= tally_wrap ? pending_reload_value : reload_value_register;
    else if (tclk_en)
      count <= count - 16'h0001;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reload_value_register <= RELOAD_0;
    else if (tally_wrap)
      reload_value_register <= pending_reload_value;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      period_tick_event <= 1'h0;
    else
      period_tick_event <= tick;
  end

  // ----------------------------------------------------------------
  // Tick tally and LED
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_tally <= 8'h00;
    else if (tally_wrap)
      tick_tally <= 8'h00;
    else if (tick)
      tick_tally <= tick_tally + 8'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      led_output_pin <= 1'h0;
    else if (tally_wrap)
      led_output_pin <= ~led_output_pin;
  end

  // ----------------------------------------------------------------
  // Switch edge and debounce
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_prev <= 1'h1;
    else
      sw_prev <= switch_input_pin_n;
  end

  assign switch_edge_event = EDGE_ENABLE &&
    ((EDGE_SEL == EDGE_SEL_FALLING) ? (sw_prev && !switch_input_pin_n)
                                    : (!sw_prev && switch_input_pin_n));

  // Wait counts ticks, so it tracks the live tick period
  assign deb_done      = (sw_state == SW_WAIT) && tick && (deb_cnt == 6'h01);
  assign still_pressed = !switch_input_pin_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_state <= SW_IDLE;
      deb_cnt  <= 6'h00;
    end
    else
    begin
      unique case (sw_state)
        SW_IDLE:
          if (switch_edge_event)
          begin
            sw_state <= SW_WAIT;
            deb_cnt  <= ilb_debounce_for(press_count);
          end
        SW_WAIT:
          if (deb_done)
            sw_state <= SW_IDLE;
          else if (tick)
            deb_cnt <= deb_cnt - 6'h01;
      endcase
    end
  end

  // Edges that land during the wait are bounce and are dropped
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      press_count          <= 2'h0;
      pending_reload_value <= RELOAD_0;
    end
    else if (deb_done && still_pressed)
    begin
      press_count          <= press_count + 2'h1;
      pending_reload_value <= reload_for(2'(press_count + 2'h1));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence wrap_s;
    tick && (tick_tally == TALLY_LAST);
  endsequence

  sequence accept_s;
    deb_done && !switch_input_pin_n;
  endsequence

  led_toggle_a: assert property (wrap_s |=> led_output_pin != $past(led_output_pin))
    else $error("LED did not invert at tally 250");
  led_only_wrap_a: assert property ($changed(led_output_pin) |-> $past(tally_wrap))
    else $error("LED changed without tally wrap");
  reload_copy_a: assert property (wrap_s |=> reload_value_register == $past(pending_reload_value))
    else $error("Reload not copied at wrap");
  reload_hold_a: assert property (!tally_wrap |=> $stable(reload_value_register))
    else $error("Reload changed between toggles");
  tick_reload_a: assert property (tick |=> count == reload_value_register)
    else $error("Counter not reloaded at tick");
  count_bound_a: assert property (count <= reload_value_register || $past(tally_wrap))
    else $error("Counter above reload value");
  pending_table_a: assert property (pending_reload_value == reload_for(press_count))
    else $error("Pending reload does not match press index");
  press_step_a: assert property (accept_s |=> press_count == 2'($past(press_count) + 2'h1))
    else $error("Press count did not advance");
  released_hold_a: assert property (deb_done && switch_input_pin_n |=> $stable(press_count))
    else $error("Released switch changed press count");
  falling_only_a: assert property ($rose(sw_state == SW_WAIT) |-> $past(sw_prev && !switch_input_pin_n))
    else $error("Debounce started without falling edge");
  deb_load_a: assert property ($rose(sw_state == SW_WAIT) |-> deb_cnt == ilb_debounce_for(press_count))
    else $error("Debounce wait loaded wrong");
  tally_range_a: assert property (tick_tally <= TALLY_LAST)
    else $error("Tick tally out of range");

endmodule

// File: core/ilb_pkg.sv
// Constants and types shared by the interval LED blinker
package ilb_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 125;
  localparam int TMR_CLK_MHZ = 32;
  // Timer clock enable made by a phase accumulator: 32 steps out of 125
  localparam logic [7:0] PHASE_STEP = 8'(TMR_CLK_MHZ);
  localparam logic [7:0] PHASE_WRAP = 8'(SYS_CLK_MHZ);

  // ----------------------------------------------------------------
  // Timer reload settings (timer clock cycles minus one)
  // ----------------------------------------------------------------
  localparam int          TICK_PERIOD_US = 2000;
  localparam logic [15:0] RELOAD_0 = 16'(TICK_PERIOD_US * TMR_CLK_MHZ - 1);
  localparam logic [15:0] RELOAD_1 = 16'(32000 - 1);
  localparam logic [15:0] RELOAD_2 = 16'(16000 - 1);
  localparam logic [15:0] RELOAD_3 = 16'(8000 - 1);

  // ----------------------------------------------------------------
  // Tick tally and debounce
  // ----------------------------------------------------------------
  localparam logic [7:0] TALLY_LAST = 8'hf9;  // 250 ticks per LED half-period
  localparam int         DEBOUNCE_MS = 10;
  localparam logic [5:0] DEBOUNCE_0 = 6'(5 + 1);
  localparam logic [5:0] DEBOUNCE_1 = 6'(10 + 1);
  localparam logic [5:0] DEBOUNCE_2 = 6'(20 + 1);
  localparam logic [5:0] DEBOUNCE_3 = 6'(40 + 1);

  // ----------------------------------------------------------------
  // Switch event setup
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_SEL_FALLING = 2'h1;
  localparam logic [1:0] EDGE_SEL         = EDGE_SEL_FALLING;
  localparam logic       EDGE_ENABLE      = 1'h1;
  localparam logic       TMR_OUT_ENABLE   = 1'h0;

  typedef logic [1:0] ilb_press_t;
  typedef enum logic [0:0] {SW_IDLE, SW_WAIT} ilb_sw_state_e;

  // Debounce wait in ticks for a press index
  function automatic logic [5:0] ilb_debounce_for(input ilb_press_t idx);
    unique case (idx)
      2'h0:    ilb_debounce_for = DEBOUNCE_0;
      2'h1:    ilb_debounce_for = DEBOUNCE_1;
      2'h2:    ilb_debounce_for = DEBOUNCE_2;
      default: ilb_debounce_for = DEBOUNCE_3;
    endcase
  endfunction

endpackage

// File: dv/ilb_blinker_tb_top.sv
// Self-checking bench for the interval LED blinker
`timescale 1ns/100ps
module ilb_blinker_tb_top;
  import ilb_pkg::*;
  // Short reloads keep the run brief; they still halve at each step
  localparam logic [15:0] RL [4] = '{16'h000f, 16'h0007, 16'h0003, 16'h0001};
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       pressed = 1'b0;
  logic       switch_input_pin_n;
  logic       led_output_pin;
  logic       period_tick_event;
  ilb_press_t press_count;
  ilb_press_t act_idx;
  ilb_press_t pc_q;
  logic       led_q;
  int         err_total = 0;
  int         n_tests = 0;
  int         cyc, tally, tick_n, g;
  logic [7:0] seed = 8'h62;

  ilb_blinker #(.RELOAD_0(RL[0]), .RELOAD_1(RL[1]), .RELOAD_2(RL[2]), .RELOAD_3(RL[3])) dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .switch_input_pin_n(switch_input_pin_n),
    .led_output_pin(led_output_pin), .period_tick_event(period_tick_event), .press_count(press_count)
  );
  ilb_switch_model sw (.sys_clk(sys_clk), .pressed(pressed), .switch_input_pin_n(switch_input_pin_n));

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Tick spacing in system clocks at a 32 of 125 timer rate
  function automatic int gap_exp(input ilb_press_t i);
    gap_exp = ((int'(RL[i]) + 1) * 125) / 32;
  endfunction
  function automatic int deb(input ilb_press_t i);
    deb = (i == 2'h0) ? int'(DEBOUNCE_0) : (i == 2'h1) ? int'(DEBOUNCE_1) :
          (i == 2'h2) ? int'(DEBOUNCE_2) : int'(DEBOUNCE_3);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      err_total++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask

  task automatic results;
    $display("mismatches %0d, comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Monitor: tick spacing follows the reload in force, LED flips every 250 ticks
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc = 0;
      tally = 0;
      act_idx = 2'h0;
      pc_q = 2'h0;
      led_q = 1'b0;
    end
    else
    begin
      cyc++;
      if (period_tick_event === 1'b1)
      begin
        tally++;
        tick_n++;
        g = gap_exp(act_idx);
        check(32'(cyc >= g - 1 && cyc <= g + 2), 32'h1);
        cyc = 0;
      end
      if (led_output_pin !== led_q)
      begin
        check(32'(tally), 32'd250);
        tally = 0;
        led_q = led_output_pin;
        // Reload was latched from the count that stood before the toggle edge
        act_idx = pc_q;
      end
      pc_q = press_count;
    end
  end

  task automatic wait_ticks(input int n);
    int t;
    int w;
    t = tick_n;
    w = 0;
    while (tick_n < t + n && w < 40000)
    begin
      @(negedge sys_clk);
      w++;
    end
    check(32'(w < 40000), 32'h1);
  endtask

  task automatic press_once(input int extra, input bit glitch);
    ilb_press_t p0;
    int         t0;
    int         w;
    p0 = press_count;
    t0 = tick_n;
    w = 0;
    pressed <= 1'b1;
    if (glitch)
    begin
      wait_ticks(2);
      pressed <= 1'b0;
      wait_ticks(50);
      check(press_count, p0);
      return;
    end
    while (press_count === p0 && w < 20000)
    begin
      @(negedge sys_clk);
      w++;
    end
    check(32'(tick_n - t0 >= deb(p0) - 1 && tick_n - t0 <= deb(p0)), 32'h1);
    check(press_count, 2'(p0 + 2'h1));
    wait_ticks(extra);
    pressed <= 1'b0;
    wait_ticks(50);
    check(press_count, 2'(p0 + 2'h1));
  endtask

  initial
  begin
    tick_n = 0;
    repeat (8) @(negedge sys_clk);
    check(led_output_pin, 1'b0);
    check(press_count, 2'h0);
    rst_n = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr_next(seed);
      press_once(int'(seed[3:0]), 1'b0);
      press_once(0, 1'b1);
    end
    wait_ticks(520);
    results();
  end

  initial
  begin
    #(100000 * 8);
    err_total++;
    results();
  end
endmodule

// File: dv/ilb_switch_model.sv
// Push switch model with contact bounce and a pull-up on the pin
`timescale 1ns/100ps
module ilb_switch_model
(
  // Clock
  input  wire logic sys_clk,
  // Request from the bench
  input  wire logic pressed,
  // Switch pin, low while closed
  output logic      switch_input_pin_n
);
  logic [2:0] bounce;
  initial
  begin
    switch_input_pin_n = 1'b1;
    bounce = 3'h0;
  end
  // A closing contact chatters before it settles; the pull-up wins when open
  always @(negedge sys_clk)
  begin
    if (!pressed)
    begin
      bounce <= 3'h0;
      switch_input_pin_n <= 1'b1;
    end
    else if (bounce != 3'h7)
    begin
      bounce <= bounce + 3'h1;
      switch_input_pin_n <= bounce[0];
    end
    else
      switch_input_pin_n <= 1'b0;
  end
endmodule
